// ==== aamc_pkg.sv ====
// Constants and types for the approach advisory mode controller
`default_nettype none
package aamc_pkg;
  // Clock rate and time figures
  localparam int CLK_HZ    = 250_000_000;
  localparam int FRAME_MS  = 1000;
  localparam int THR_MS    = 3000;
  localparam int FLASH_MS  = 500;
  // Cycle counts; every time comes out exact at this clock
  localparam int FRAME_CYC = CLK_HZ / 1000 * FRAME_MS;
  localparam int THR_CYC   = CLK_HZ / 1000 * THR_MS;
  localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  // Length of the startup sequence
  localparam int INIT_CYC  = 16;
  // Register indices
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  // Control register bits and reset value
  localparam int CTRL_LTEST = 0;
  localparam int CTRL_MCLR  = 1;
  localparam logic CTRL_RST = 1'h0;
  // Selector positions in panel order
  typedef enum logic [2:0] {
    SEL_OFF = 3'h0, SEL_TEST = 3'h1, SEL_WEIGHT = 3'h2,
    SEL_VREF = 3'h3, SEL_FINAL = 3'h4, SEL_FIELD = 3'h5,
    SEL_HMIN = 3'h6, SEL_GS = 3'h7
  } aamc_sel_type;
  // Operating modes
  typedef enum logic [2:0] {
    M_OFF = 3'h0, M_PWRUP = 3'h1, M_STBY = 3'h2,
    M_COMP = 3'h3, M_INOPERATIVE_INDICATOR = 3'h4, M_MTEST = 3'h5
  } aamc_mode_type;
  // Steps of one compute frame
  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_TEST = 2'h1, S_WAIT = 2'h2
  } aamc_step_type;
  // Numeric display contents
  typedef enum logic [2:0] {
    D_BLANK = 3'h0, D_PILOT = 3'h1, D_ALL = 3'h2, D_DATA = 3'h3,
    D_FLAG = 3'h4, D_FAIL = 3'h5, D_FAST = 3'h6, D_SEGS = 3'h7
  } aamc_disp_type;
  // Annunciator panel drive
  typedef struct packed {
    logic inoperative_indicator;
    logic thr_digit;
    logic thr;
    logic gear;
    logic flap;
    logic flap_digit;
  } aamc_lamp_type;
  // Panel pins, sampled together
  typedef struct packed {
    aamc_sel_type sel;
    logic maint;
    logic inoperative_indicator;
    logic comp;
    logic clr;
    logic thr;
    logic gear;
    logic flap;
    logic pwr;
  } aamc_pin_type;
endpackage
`default_nettype wire

// ==== aamc_mode_ctrl.sv ====
// Mode sequencer of the approach advisory computer
`default_nettype none
module aamc_mode_ctrl
  import aamc_pkg::*;
#(
  parameter int FRAME_CYC_P = FRAME_CYC,
  parameter int THR_CYC_P   = THR_CYC,
  parameter int FLASH_CYC_P = FLASH_CYC
) (
  // Clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          resetn_i,
  // Panel pins, asynchronous
  input  wire logic          power_ok_i,
  input  wire logic [2:0]    sel_i,
  input  wire logic          key_clear_i,
  input  wire logic          key_compute_i,
  input  wire logic          inoperative_indicator_press_i,
  input  wire logic          maint_sw_i,
  input  wire logic          flap_set_i,
  input  wire logic          gear_set_i,
  input  wire logic          thr_set_i,
  // Algorithm and self-test, same clock
  input  wire logic          test_done_i,
  input  wire logic          test_pass_i,
  input  wire logic          test_benign_i,
  input  wire aamc_disp_type test_code_i,
  input  wire logic          overshoot_warning_flag_i,
  input  wire logic          cmd_flap_i,
  input  wire logic          cmd_gear_i,
  input  wire logic          cmd_thrust_i,
  input  wire logic          approach_power_command_i,
  input  wire logic          pointer_valid_i,
  input  wire logic          maint_done_i,
  input  wire logic          maint_fault_i,
  // Register port
  input  wire logic [1:0]    addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output var  logic [31:0]   rdata_o,
  // Mode and requests
  output var  aamc_mode_type mode_o,
  output var  logic          sys_on_o,
  output var  logic          init_o,
  output var  logic          test_req_o,
  output var  logic          predict_req_o,
  output var  logic          frame_o,
  output var  logic          vref_calc_o,
  output var  logic          maint_req_o,
  output var  logic          maint_fault_o,
  // Panel drive
  output var  aamc_lamp_type lamp_o,
  output var  logic          pointer_on_o,
  output var  aamc_disp_type disp_o,
  output var  aamc_sel_type  disp_sel_o,
  output var  logic          entry_en_o
);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Pin synchroniser stages; s1 feeds only s2
  aamc_pin_type s1, s2, s3;
  // Rising edges of synchronised pins
  aamc_pin_type rise;
  // Power present and selector out of off position
  logic         run;

  // Two flops per pin, third for edge detect
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= {sel_i, maint_sw_i, inoperative_indicator_press_i, key_compute_i,
             key_clear_i, thr_set_i, gear_set_i, flap_set_i,
             power_ok_i};
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign rise = s2 & ~s3;
  // Off position removes power in the real panel
  assign run  = s2.pwr && (s2.sel != SEL_OFF);

  // Control register and software lamp test
  logic ltest, next_ltest;
  logic [31:0] next_rdata;

  // Controller state
  aamc_step_type step, next_step;        // Frame step
  aamc_disp_type code, next_code;        // Latched fault code
  logic [4:0]    icnt, next_icnt;        // Startup count
  logic [31:0]   fcnt, next_fcnt;        // Frame divider
  logic [31:0]   tcnt, next_tcnt;        // Thrust grace timer
  logic [31:0]   bcnt, next_bcnt;        // Flash divider
  logic          blink, next_blink;      // Half-second toggle
  logic          tact, next_tact;        // Grace timer running
  logic          flash, next_flash;      // Thrust lamp flashing
  logic          fl, next_fl;            // Flap command lit
  logic          ge, next_ge;            // Gear command lit
  logic          th, next_th;            // Thrust command lit
  aamc_mode_type next_mode;
  logic          next_init, next_treq, next_preq, next_frame;
  logic          next_mreq, next_mflt, next_ptr, next_vref;
  logic          next_on, next_entry;
  aamc_lamp_type next_lamp;
  aamc_disp_type next_disp;

  // Register port: decode and one-cycle read data
  always_comb begin
    next_ltest = ltest;
    next_rdata = 32'h0000_0000;
    if (wr_i && addr_i == REG_CTRL) begin
      next_ltest = wdata_i[CTRL_LTEST];
    end
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: next_rdata = {31'h0000_0000, ltest};
        REG_STAT: next_rdata = {16'h0000, code, step, mode_o,
                                maint_fault_o, pointer_on_o, lamp_o};
        // Unmapped indices read zero
        default:  next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ltest   <= CTRL_RST;
      rdata_o <= 32'h0000_0000;
    end else begin
      ltest   <= next_ltest;
      rdata_o <= next_rdata;
    end
  end

  // Mode sequencer, timers and lamp latches
  always_comb begin
    next_mode  = mode_o;
    next_step  = step;
    next_code  = code;
    next_icnt  = '0;
    next_tcnt  = tcnt;
    next_tact  = tact;
    next_flash = flash;
    next_fl    = fl;
    next_ge    = ge;
    next_th    = th;
    next_ptr   = pointer_on_o;
    next_treq  = 1'b0;
    next_preq  = 1'b0;
    next_mreq  = 1'b0;
    next_frame = 1'b0;
    next_fcnt  = '0;
    next_mflt  = maint_fault_o;
    // Software clear first, so a fault found now survives
    if (wr_i && addr_i == REG_CTRL && wdata_i[CTRL_MCLR]) begin
      next_mflt = 1'b0;
    end
    // Free-running flash toggle
    next_bcnt  = bcnt + 32'd1;
    next_blink = blink;
    if (bcnt == 32'(FLASH_CYC_P - 1)) begin
      next_bcnt  = '0;
      next_blink = ~blink;
    end
    // Frame strobe paces the loop
    if (mode_o == M_COMP) begin
      if (fcnt == 32'(FRAME_CYC_P - 1)) begin
        next_frame = 1'b1;
      end else begin
        next_fcnt = fcnt + 32'd1;
      end
    end
    if (!run) begin
      // Off or power loss ends every mode
      next_mode = M_OFF;
      next_step = S_IDLE;
    end else begin
      unique case (mode_o)
        M_OFF: begin
          next_mode = M_PWRUP;
        end
        M_PWRUP: begin
          // Hold init long enough for the data reset
          next_icnt = icnt + 5'd1;
          if (icnt == 5'(INIT_CYC - 1)) begin
            next_mode = M_STBY;
          end
        end
        M_STBY: begin
          if (rise.comp && s2.sel != SEL_TEST) begin
            // Engage: first test at once
            next_mode = M_COMP;
            next_step = S_TEST;
            next_treq = 1'b1;
            next_ptr  = 1'b0;
          end else if (rise.maint) begin
            // Maintenance only from standby
            next_mode = M_MTEST;
            next_mreq = 1'b1;
          end
        end
        M_COMP: begin
          if (rise.clr || rise.inoperative_indicator) begin
            next_mode = M_STBY;
          end else if (overshoot_warning_flag_i) begin
            next_mode = M_INOPERATIVE_INDICATOR;
            next_code = D_FAST;
          end else if (step == S_TEST && test_done_i && !test_pass_i) begin
            // Cause decides standby or inoperative
            if (test_benign_i) begin
              next_mode = M_STBY;
            end else begin
              next_mode = M_INOPERATIVE_INDICATOR;
              // Only fault words are shown
              next_code = (test_code_i >= D_DATA) ? test_code_i : D_FAIL;
            end
          end else if (step == S_TEST && test_done_i) begin
            next_preq = 1'b1;
            next_step = S_WAIT;
          end else if (step == S_WAIT && next_frame) begin
            next_treq = 1'b1;
            next_step = S_TEST;
          end
          // Pointer comes up with its first value
          if (pointer_valid_i) begin
            next_ptr = 1'b1;
          end
        end
        M_INOPERATIVE_INDICATOR: begin
          // Everything but clear and inoperative_indicator ignored
          if (rise.clr || rise.inoperative_indicator) begin
            next_mode = M_STBY;
          end
        end
        M_MTEST: begin
          // Momentary: back once the test is over
          if (maint_done_i) begin
            next_mode = M_STBY;
            next_mflt = maint_fault_o | maint_fault_i;
          end
        end
        default: begin
          next_mode = M_OFF;
        end
      endcase
    end
    if (next_mode != M_COMP) begin
      next_step = S_IDLE;
    end
    // Command lamps live only while computing
    if (mode_o == M_COMP && next_mode == M_COMP) begin
      // Pilot response blanks; a new command wins
      if (rise.flap) next_fl = 1'b0;
      if (rise.gear) next_ge = 1'b0;
      if (rise.thr) begin
        next_th    = 1'b0;
        next_tact  = 1'b0;
        next_flash = 1'b0;
      end
      // Due command lights steadily, no alert first
      if (cmd_flap_i) next_fl = 1'b1;
      if (cmd_gear_i) next_ge = 1'b1;
      if (cmd_thrust_i) begin
        next_th    = 1'b1;
        next_flash = 1'b0;
      end
      // Approach power starts the three-second grace
      if (approach_power_command_i) begin
        next_th    = 1'b1;
        next_tact  = 1'b1;
        next_tcnt  = '0;
        next_flash = 1'b0;
      end else if (tact) begin
        next_tcnt = tcnt + 32'd1;
        if (tcnt == 32'(THR_CYC_P - 1)) begin
          next_tact  = 1'b0;
          next_flash = 1'b1;
        end
      end
    end else begin
      next_fl    = 1'b0;
      next_ge    = 1'b0;
      next_th    = 1'b0;
      next_tact  = 1'b0;
      next_flash = 1'b0;
      next_tcnt  = '0;
      next_ptr   = 1'b0;
    end
  end

  // Panel drive follows the present mode
  always_comb begin
    next_lamp  = '0;
    next_disp  = D_BLANK;
    next_entry = 1'b0;
    next_vref  = 1'b0;
    next_init  = (mode_o == M_PWRUP);
    next_on    = (mode_o != M_OFF);
    unique case (mode_o)
      M_STBY: begin
        // Reference speed kept current from weight
        next_vref = 1'b1;
        if (s2.sel == SEL_TEST || ltest) begin
          next_lamp = '1;
          next_disp = D_ALL;
        end else begin
          // Lamps stay dark in standby
          next_disp = D_PILOT;
          // Weight and later, except derived speed
          next_entry = (s2.sel >= SEL_WEIGHT) && (s2.sel != SEL_VREF);
        end
      end
      M_COMP: begin
        // Display only; no entry while computing
        next_disp            = D_PILOT;
        next_lamp.flap_digit = 1'b1;
        next_lamp.flap       = fl;
        next_lamp.gear       = ge;
        next_lamp.thr        = th & (~flash | blink);
        next_lamp.thr_digit  = th;
      end
      M_INOPERATIVE_INDICATOR: begin
        next_lamp.inoperative_indicator = 1'b1;
        next_disp      = code;
      end
      M_MTEST: begin
        next_disp = D_PILOT;
      end
      default: begin
        next_disp = D_BLANK;
      end
    endcase
  end

  // Register all controller state and outputs except rdata_o
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      mode_o        <= M_OFF;
      step          <= S_IDLE;
      code          <= D_BLANK;
      icnt          <= '0;
      fcnt          <= '0;
      tcnt          <= '0;
      bcnt          <= '0;
      blink         <= 1'b0;
      tact          <= 1'b0;
      flash         <= 1'b0;
      fl            <= 1'b0;
      ge            <= 1'b0;
      th            <= 1'b0;
      sys_on_o      <= 1'b0;
      init_o        <= 1'b0;
      test_req_o    <= 1'b0;
      predict_req_o <= 1'b0;
      frame_o       <= 1'b0;
      vref_calc_o   <= 1'b0;
      maint_req_o   <= 1'b0;
      maint_fault_o <= 1'b0;
      lamp_o        <= '0;
      pointer_on_o  <= 1'b0;
      disp_o        <= D_BLANK;
      disp_sel_o    <= SEL_OFF;
      entry_en_o    <= 1'b0;
    end else begin
      mode_o        <= next_mode;
      step          <= next_step;
      code          <= next_code;
      icnt          <= next_icnt;
      fcnt          <= next_fcnt;
      tcnt          <= next_tcnt;
      bcnt          <= next_bcnt;
      blink         <= next_blink;
      tact          <= next_tact;
      flash         <= next_flash;
      fl            <= next_fl;
      ge            <= next_ge;
      th            <= next_th;
      sys_on_o      <= next_on;
      init_o        <= next_init;
      test_req_o    <= next_treq;
      predict_req_o <= next_preq;
      frame_o       <= next_frame;
      vref_calc_o   <= next_vref;
      maint_req_o   <= next_mreq;
      maint_fault_o <= next_mflt;
      lamp_o        <= next_lamp;
      pointer_on_o  <= next_ptr;
      disp_o        <= next_disp;
      disp_sel_o    <= s2.sel;
      entry_en_o    <= next_entry;
    end
  end

  // Checks on mode changes and panel drive
  pwrup_entry_a: assert property (
    mode_o == M_OFF && run |=> mode_o == M_PWRUP)
    else $error("power-up not entered");

  pwrup_len_a: assert property (
    mode_o == M_PWRUP && $past(mode_o) != M_PWRUP
    |-> ##[1:16] (mode_o == M_STBY || mode_o == M_OFF))
    else $error("power-up too long");

  lamp_test_a: assert property (
    mode_o == M_STBY && s2.sel == SEL_TEST |=> lamp_o == '1)
    else $error("lamp test not lit");

  stby_dark_a: assert property (
    mode_o == M_STBY && s2.sel != SEL_TEST && !ltest
    |=> lamp_o == '0 && !pointer_on_o && vref_calc_o)
    else $error("standby panel not dark");

  clear_back_a: assert property (
    (mode_o == M_COMP || mode_o == M_INOPERATIVE_INDICATOR) && run
    && (rise.clr || rise.inoperative_indicator) |=> mode_o == M_STBY)
    else $error("clear did not return to standby");

  comp_from_a: assert property (
    mode_o == M_COMP && $past(mode_o) != M_COMP
    |-> $past(mode_o) == M_STBY && test_req_o)
    else $error("compute not from standby");

  ovs_inoperative_indicator_a: assert property (
    mode_o == M_COMP && run && !rise.clr && !rise.inoperative_indicator
    && overshoot_warning_flag_i |=> mode_o == M_INOPERATIVE_INDICATOR ##1 disp_o == D_FAST)
    else $error("overshoot not inoperative");

  inoperative_indicator_only_a: assert property (
    mode_o == M_INOPERATIVE_INDICATOR |=> lamp_o == aamc_lamp_type'(6'h20))
    else $error("inoperative lamps wrong");

  inoperative_indicator_hold_a: assert property (
    mode_o == M_INOPERATIVE_INDICATOR && run && !rise.clr && !rise.inoperative_indicator |=> mode_o == M_INOPERATIVE_INDICATOR)
    else $error("inoperative left wrongly");

  flap_digit_a: assert property (
    mode_o == M_COMP |=> lamp_o.flap_digit && !entry_en_o)
    else $error("flap digit dark in compute");

  frame_len_a: assert property (
    fcnt < 32'(FRAME_CYC_P))
    else $error("frame too long");

  comp_run_c: cover property (mode_o == M_COMP ##1 predict_req_o);
  inoperative_indicator_c: cover property (mode_o == M_COMP ##1 mode_o == M_INOPERATIVE_INDICATOR);
  mtest_c: cover property (mode_o == M_MTEST ##1 mode_o == M_STBY);
  flash_c: cover property (th && flash);

endmodule // aamc_mode_ctrl
`default_nettype wire

// ==== aamc_panel_model.sv ====
// Pilot panel and position sensor model facing the mode controller
`default_nettype none
module aamc_panel_model
  import aamc_pkg::*;
#(
  parameter int REACT_CYC = 4  // Pilot reaction time in cycles
) (
  // Clock
  input  wire logic          ref_clk_i,
  // Annunciator drive seen by the pilot
  input  wire aamc_lamp_type lamp_i,
  // Scenario controls
  input  wire aamc_sel_type  sel_want_i,
  input  wire logic          thr_hold_i,
  // Selector and position sensors {thr, gear, flap}
  output var  logic [2:0]    sel_o,
  output var  logic [2:0]    sensor_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] due;      // Commands the pilot is acting on
  int         cnt [3];  // Reaction counters

  // Selector shows the wanted one of eight ordered positions directly
  assign sel_o = sel_want_i;
  // Held throttles model a pilot who ignores the thrust command
  assign due = {(lamp_i.thr | lamp_i.thr_digit) & ~thr_hold_i, lamp_i.gear, lamp_i.flap};

  // Sensors start low so the first command sees a clean rise
  initial sensor_o = 3'h0;

  // Lever moves after a reaction time; it drops once the lamp blanks so the next command gives a fresh rise
  always @(posedge ref_clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (!due[i]) begin
        cnt[i]      <= 0;
        sensor_o[i] <= 1'b0;
      end else if (cnt[i] == REACT_CYC) begin
        sensor_o[i] <= 1'b1;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule // aamc_panel_model
`default_nettype wire

// ==== test_approach_advisory_mode_controller.sv ====
// Self-checking bench for the approach advisory mode controller
`default_nettype none
module test_approach_advisory_mode_controller
  import aamc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Design inputs
  logic          ref_clk_i, resetn_i, power_ok_i, wr_i, rd_i;
  logic          test_done_i, test_pass_i, test_benign_i, overshoot_warning_flag_i;
  logic          pointer_valid_i, maint_done_i, maint_fault_i;
  logic          key_clear_i, key_compute_i, inoperative_indicator_press_i, maint_sw_i;
  logic          cmd_flap_i, cmd_gear_i, cmd_thrust_i, approach_power_command_i;
  logic          flap_set_i, gear_set_i, thr_set_i;
  logic [2:0]    sel_i;
  logic [1:0]    addr_i;
  logic [31:0]   wdata_i;
  aamc_disp_type test_code_i;
  // Design outputs
  logic [31:0]   rdata_o;
  aamc_mode_type mode_o;
  logic          sys_on_o, init_o, test_req_o, predict_req_o, frame_o;
  logic          vref_calc_o, maint_req_o, maint_fault_o, pointer_on_o, entry_en_o;
  aamc_lamp_type lamp_o;
  aamc_disp_type disp_o;
  aamc_sel_type  disp_sel_o;
  // Bench state
  logic [3:0]    keys, cmds;
  aamc_sel_type  sel_want;
  logic          thr_hold, last;
  logic [31:0]   rv;
  int            fails, n_compared, c, tg;
  // Standby selector table: position and expected display
  typedef struct packed {aamc_sel_type sel; aamc_disp_type disp;} aamc_row_type;
  aamc_row_type  rows [7] = '{'{SEL_TEST, D_ALL}, '{SEL_VREF, D_PILOT}, '{SEL_FINAL, D_PILOT},
    '{SEL_FIELD, D_PILOT}, '{SEL_HMIN, D_PILOT}, '{SEL_GS, D_PILOT}, '{SEL_WEIGHT, D_PILOT}};

  // Keys: clear, compute, inoperative_indicator press, maintenance
  assign {maint_sw_i, inoperative_indicator_press_i, key_compute_i, key_clear_i} = keys;
  assign {approach_power_command_i, cmd_thrust_i, cmd_gear_i, cmd_flap_i} = cmds;
  // Pulses watched: test, predict, frame, maintenance
  wire logic [3:0] pulses = {maint_req_o, frame_o, predict_req_o, test_req_o};

  // Short counts keep the run brief
  aamc_mode_ctrl #(.FRAME_CYC_P(40), .THR_CYC_P(100), .FLASH_CYC_P(8)) i_dut (.*);
  aamc_panel_model i_panel (.ref_clk_i, .lamp_i(lamp_o), .sel_want_i(sel_want), .thr_hold_i(thr_hold),
                            .sel_o(sel_i), .sensor_o({thr_set_i, gear_set_i, flap_set_i}));

  // Clock, 4 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One edge, then let its updates settle
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_mode(input aamc_mode_type m, input int n);
    for (int i = 0; i < n && mode_o !== m; i++) tick();
    chk("mode", mode_o, m);
  endtask
  task automatic wait_bit(input string nm, input int b, input int n);
    for (int i = 0; i < n && pulses[b] !== 1'b1; i++) tick();
    chk(nm, pulses[b], 1'b1);
  endtask
  // Held three cycles so the synchroniser sees one clean press
  task automatic press(input int k);
    @(posedge ref_clk_i) keys[k] <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    keys[k] <= 1'b0;
    #1;
  endtask
  task automatic pulse_cmd(input logic [3:0] m);
    @(posedge ref_clk_i) cmds <= m;
    @(posedge ref_clk_i) cmds <= 4'h0;
    #1;
  endtask
  task automatic result(input logic p, input logic b, input aamc_disp_type code);
    @(posedge ref_clk_i);
    test_done_i   <= 1'b1;
    test_pass_i   <= p;
    test_benign_i <= b;
    test_code_i   <= code;
    @(posedge ref_clk_i) test_done_i <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i) wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i) rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic enter_comp();
    press(1);
    wait_mode(M_COMP, 8);
    chk("first test", test_req_o, 1'b1);
    tick();
    chk("flap digit", lamp_o.flap_digit, 1'b1);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    final_report();
  end

  initial begin
    {resetn_i, power_ok_i, wr_i, rd_i, test_done_i, test_pass_i, test_benign_i} = 7'h00;
    {overshoot_warning_flag_i, pointer_valid_i, maint_done_i, maint_fault_i, thr_hold} = 5'h00;
    {keys, cmds, addr_i} = 10'h000;
    wdata_i = 32'h0000_0000;
    test_code_i = D_BLANK;
    sel_want = SEL_OFF;
    repeat (12) tick();
    chk("reset mode", mode_o, M_OFF);
    chk("reset lamps", lamp_o, 6'h00);
    @(posedge ref_clk_i) resetn_i <= 1'b1;
    // Power and selector out of off start the power-up sequence
    @(posedge ref_clk_i);
    power_ok_i <= 1'b1;
    sel_want   <= SEL_WEIGHT;
    wait_mode(M_PWRUP, 6);
    // Init flag is registered from the mode, one edge behind it
    tick();
    chk("init", init_o, 1'b1);
    wait_mode(M_STBY, 24);
    tick();
    chk("stby lamps", lamp_o, 6'h00);
    chk("stby pointer", pointer_on_o, 1'b0);
    chk("stby entry", entry_en_o, 1'b1);
    chk("vref calc", vref_calc_o, 1'b1);
    chk("no predict", predict_req_o, 1'b0);
    // Every selector position but off in standby
    foreach (rows[i]) begin
      @(posedge ref_clk_i) sel_want <= rows[i].sel;
      repeat (5) tick();
      chk("disp sel", disp_sel_o, rows[i].sel);
      chk("disp", disp_o, rows[i].disp);
      chk("stby kept", mode_o, M_STBY);
    end
    // Register port, unmapped place included
    rd(2'h1);
    chk("status mode", rv[10:8], M_STBY);
    rd(2'h0);
    chk("ctrl reset", rv, 32'h0000_0000);
    wr(2'h3, 32'hffff_ffff);
    rd(2'h3);
    chk("unmapped", rv, 32'h0000_0000);
    wr(2'h0, 32'h0000_0001);
    rd(2'h0);
    chk("ctrl rw", rv, 32'h0000_0001);
    tick();
    chk("lamp test", lamp_o, 6'h3f);
    wr(2'h0, 32'h0000_0000);
    // Compute frame loop and command lamps
    enter_comp();
    result(1'b1, 1'b0, D_BLANK);
    wait_bit("predict", 1, 3);
    @(posedge ref_clk_i) pointer_valid_i <= 1'b1;
    @(posedge ref_clk_i) pointer_valid_i <= 1'b0;
    repeat (4) tick();
    chk("pointer", pointer_on_o, 1'b1);
    wait_bit("frame", 2, 45);
    chk("frame test", test_req_o, 1'b1);
    result(1'b1, 1'b0, D_BLANK);
    for (c = 0; c < 2; c++) begin
      pulse_cmd(4'h1 << c);
      repeat (2) tick();
      chk("cmd lamp", lamp_o[c+1], 1'b1);
      repeat (14) tick();
      chk("cmd blank", lamp_o[c+1], 1'b0);
      chk("flap digit kept", lamp_o.flap_digit, 1'b1);
    end
    @(posedge ref_clk_i) sel_want <= SEL_FINAL;
    repeat (5) tick();
    chk("no entry", entry_en_o, 1'b0);
    chk("comp sel", disp_sel_o, SEL_FINAL);
    // Approach power with throttles held back
    @(posedge ref_clk_i) thr_hold <= 1'b1;
    pulse_cmd(4'hc);
    repeat (90) tick();
    chk("thr steady", lamp_o.thr, 1'b1);
    repeat (14) tick();
    last = lamp_o.thr;
    tg = 0;
    repeat (24) begin
      tick();
      if (lamp_o.thr !== last) tg++;
      last = lamp_o.thr;
    end
    chk("thr flash", tg >= 2, 1'b1);
    @(posedge ref_clk_i) thr_hold <= 1'b0;
    repeat (20) tick();
    chk("thr blank", lamp_o.thr, 1'b0);
    // Overshoot ends compute; of the keys only clear or inoperative_indicator press leaves
    @(posedge ref_clk_i) overshoot_warning_flag_i <= 1'b1;
    wait_mode(M_INOPERATIVE_INDICATOR, 6);
    @(posedge ref_clk_i) overshoot_warning_flag_i <= 1'b0;
    tick();
    chk("inoperative_indicator lamps", lamp_o, 6'h20);
    chk("fast code", disp_o, D_FAST);
    press(1);
    repeat (3) tick();
    chk("compute ignored", mode_o, M_INOPERATIVE_INDICATOR);
    press(0);
    wait_mode(M_STBY, 6);
    // Each fault code, left by clear or inoperative_indicator press in turn
    for (c = 3; c <= 7; c++) begin
      enter_comp();
      result(1'b0, 1'b0, aamc_disp_type'(c));
      wait_mode(M_INOPERATIVE_INDICATOR, 4);
      tick();
      chk("fault code", disp_o, c);
      press(c[0] ? 2 : 0);
      wait_mode(M_STBY, 6);
    end
    enter_comp();
    result(1'b0, 1'b1, D_DATA);
    wait_mode(M_STBY, 4);
    enter_comp();
    press(0);
    wait_mode(M_STBY, 6);
    // Selector off shuts down inoperative mode
    enter_comp();
    result(1'b0, 1'b0, D_FAIL);
    wait_mode(M_INOPERATIVE_INDICATOR, 4);
    @(posedge ref_clk_i) sel_want <= SEL_OFF;
    wait_mode(M_OFF, 6);
    tick();
    chk("off lamps", lamp_o, 6'h00);
    @(posedge ref_clk_i) sel_want <= SEL_WEIGHT;
    wait_mode(M_PWRUP, 6);
    wait_mode(M_STBY, 24);
    // Maintenance test with a fault, then software clears it
    press(3);
    wait_bit("maint req", 3, 8);
    chk("maint mode", mode_o, M_MTEST);
    @(posedge ref_clk_i) {maint_done_i, maint_fault_i} <= 2'h3;
    @(posedge ref_clk_i) {maint_done_i, maint_fault_i} <= 2'h0;
    wait_mode(M_STBY, 4);
    tick();
    chk("maint fault", maint_fault_o, 1'b1);
    wr(2'h0, 32'h0000_0002);
    repeat (2) tick();
    chk("fault cleared", maint_fault_o, 1'b0);
    // Power loss and return
    @(posedge ref_clk_i) power_ok_i <= 1'b0;
    wait_mode(M_OFF, 6);
    // System-on flag follows the mode one edge later
    tick();
    chk("sys off", sys_on_o, 1'b0);
    @(posedge ref_clk_i) power_ok_i <= 1'b1;
    wait_mode(M_PWRUP, 6);
    final_report();
  end
endmodule // test_approach_advisory_mode_controller
`default_nettype wire
